/* File: common/pwr_mgmt_regs.vh */
/*
 * Constants for the Ethernet power state manager: register byte addresses,
 * field positions, power state codes, wake source codes and timing figures.
 * Assumes a 32-bit classic Wishbone slave port clocked at 10 MHz.
 */
// Function
// - Register contents and configuration survive both low-power states.
// - Writing 01 to power state select enters wake-on-LAN state.
// - Wake-on-LAN gates MAC and host clocks; internal clock and receive block run.
// - Energy-detect state gates MAC, host and internal clocks; PHY in energy mode (code: only while PHY energy power-down bit is set).
// - Ready flag clears on entering either low-power state.
// - Any write to wake test register wakes device and resets state select.
// - Writes ignored until one read after reset or wake; host does that read.
// - Wake-on-LAN enables frame detection; detection sets wake source to 10b.
// - In wake-on-LAN, frame detection with both enables asserts wake output.
// - In energy-detect, carrier with both enables asserts wake output, source 01b.
// - Carrier present on entry to energy-detect is detected at once.
// - Wake interrupt flag sets on any wake event regardless of pin enable.
// - Flag sticks while internal wake cause is active; then write-one clears.
// - Pulse select one drives wake output for 50 ms per event.
// - Pulse select zero holds wake output until deactivated.
// - Wake output drops when source, matching enable or pin enable clears.
// - PHY general power-down bit keeps PHY down; clearing it resets PHY.
// - PHY energy power-down sleeps without energy; energy wakes it, sets flag.
// - Ready sets within 2 ms of the wake-up write.
`ifndef PWR_MGMT_REGS_VH
`define PWR_MGMT_REGS_VH

`define ADDR_PMCTRL 6'h00
`define ADDR_INTSTS 6'h04
`define ADDR_INTEN 6'h08
`define ADDR_WAKETEST 6'h0C
`define ADDR_PHYCTRL 6'h10
`define ADDR_PHYSTS 6'h14

// Power control register fields.
`define PM_READY_BIT 0
`define PM_WPIN_EN_BIT 1
`define PM_PULSE_BIT 3
`define PM_FRAME_EN_BIT 9
`define PM_ENERGY_EN_BIT 10
`define PM_SRC_LO 4
`define PM_SRC_HI 5
`define PM_STATE_LO 12
`define PM_STATE_HI 13

`define PSTATE_NORMAL 2'h0
`define PSTATE_WOL 2'h1
`define PSTATE_ENERGY 2'h2
`define WSRC_NONE 2'h0
`define WSRC_ENERGY 2'h1
`define WSRC_FRAME 2'h2

`define INT_WAKE_BIT 17
`define PHY_GPD_BIT 11
`define PHY_EDPD_BIT 13
`define PHY_ENFLAG_BIT 1

`define WAKE_TEST_VALUE 32'h8765_4321
`define CLK_HZ 10000000
`define PULSE_MS 50
`define READY_MAX_MS 2
`define RESTART_CYCLES 16

`endif

/* File: hdl/wake_pulse_timer.v */
/*
 * One-shot timer for the wake event output pulse mode.
 * Assumes start and clear are synchronous one-cycle or level inputs on clk_i.
 */
`timescale 1ns/1ps
`include "pwr_mgmt_regs.vh"

module wake_pulse_timer #(
    parameter CYCLES = `CLK_HZ / 1000 * `PULSE_MS
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Control.
    input wire start_i,
    input wire clear_i,
    // Status.
    output reg busy_o
);
    localparam integer LAST_I = CYCLES - 1;
    localparam [19:0] LAST = LAST_I[19:0];
    reg [19:0] count_r;

    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count_r <= 20'h0_0000;
            busy_o <= 1'b0;
        end else if (start_i) begin
            count_r <= 20'h0_0000;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            if (count_r == LAST) begin
                busy_o <= 1'b0;
            end else begin
                count_r <= count_r + 20'h0_0001;
            end
        end
    end
endmodule // wake_pulse_timer

/* File: hdl/pwr_state_mgr.v */
/*
 * Power state manager: normal, wake-on-LAN and energy-detect states, clock
 * gating enables, ready flag, wake-up write, wake source, wake interrupt flag
 * and wake event output, plus the internal PHY power-down controls.
 * Assumes a classic Wishbone master on clk_i, and frame detect and line energy
 * signals that come from other clock domains and are synchronised here.
 */
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "pwr_mgmt_regs.vh"

module pwr_state_mgr #(
    parameter PULSE_CYCLES = `CLK_HZ / 1000 * `PULSE_MS,
    parameter RESTART_CYCLES = `RESTART_CYCLES
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave.
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Line side events.
    input wire wake_frame_i,
    input wire line_energy_present_i,
    // Clock gating and PHY control.
    output reg mac_clk_en_o,
    output reg host_clk_en_o,
    output reg int_clk_en_o,
    output reg rx_pm_clk_en_o,
    output reg phy_powerdown_o,
    output reg phy_energy_mode_o,
    output reg phy_reset_o,
    // Wake indications.
    output reg wake_event_o,
    output reg wake_irq_o
);
    localparam [3:0] ST_NORMAL = 4'b0001;
    localparam [3:0] ST_WOL = 4'b0010;
    localparam [3:0] ST_ENERGY = 4'b0100;
    localparam [3:0] ST_RESTART = 4'b1000;
    localparam integer RESTART_LAST_I = RESTART_CYCLES - 1;
    localparam [7:0] RESTART_LAST = RESTART_LAST_I[7:0];

    // Full readable register word with byte-lane writes applied.
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer i;
        begin
            lane_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    lane_merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // Write strobe for one register while ready; the wake test port is decoded apart.
    function reg_write;
        input wr_seen;
        input ready;
        input [5:0] adr;
        input [5:0] target;
        begin
            reg_write = wr_seen && ready && (adr == target);
        end
    endfunction

    reg [3:0] state_r;
    reg [7:0] restart_cnt_r;
    reg ready_r;
    reg read_seen_r;
    reg wpin_en_r;
    reg pulse_sel_r;
    reg frame_en_r;
    reg energy_en_r;
    reg [1:0] src_r;
    reg [1:0] sel_state_r;
    reg int_wake_r;
    reg int_en_r;
    reg phy_gpd_r;
    reg phy_edpd_r;
    reg phy_enflag_r;
    reg phy_gpd_d_r;
    reg frame_s1_r;
    reg frame_s2_r;
    reg energy_s1_r;
    reg energy_s2_r;
    reg energy_d_r;
    reg wake_level_r;
    reg [31:0] rd_nxt;

    wire access = cyc_i && stb_i && !ack_o;
    wire wr = access && we_i;
    wire rd = access && !we_i;
    // Host writes are dropped until the first read after reset or wake.
    wire wr_ok = wr && read_seen_r;
    wire in_wol = (state_r == ST_WOL);
    wire in_energy = (state_r == ST_ENERGY);
    wire frame_hit = in_wol && frame_s2_r;
    // Level compare, so carrier already present on entry counts at once.
    wire energy_hit = in_energy && energy_s2_r;
    wire [31:0] pm_word = {18'h0_0000, sel_state_r, 1'b0, energy_en_r, frame_en_r,
        3'h0, src_r, 1'b0, pulse_sel_r, wpin_en_r, ready_r};
    wire [31:0] pm_new = lane_merge(pm_word, dat_i, sel_i);
    wire pm_wr = reg_write(wr_ok, ready_r, adr_i, `ADDR_PMCTRL);
    wire interrupt_status_reg_wr = reg_write(wr_ok, ready_r, adr_i, `ADDR_INTSTS);
    wire int_en_wr = reg_write(wr_ok, ready_r, adr_i, `ADDR_INTEN);
    wire phy_ctrl_wr = reg_write(wr_ok, ready_r, adr_i, `ADDR_PHYCTRL);
    wire phy_sts_wr = reg_write(wr_ok, ready_r, adr_i, `ADDR_PHYSTS);
    wire pm_enter_wol = pm_wr && (pm_new[`PM_STATE_HI:`PM_STATE_LO] == `PSTATE_WOL);
    wire pm_enter_energy = pm_wr && (pm_new[`PM_STATE_HI:`PM_STATE_LO] == `PSTATE_ENERGY);
    // Wake test write is accepted whatever the ready flag shows.
    wire wake_wr = wr_ok && (adr_i == `ADDR_WAKETEST) && (in_wol || in_energy);
    // Internal wake cause: a latched source whose matching enable is still set.
    wire cause = ((src_r == `WSRC_FRAME) && frame_en_r) || ((src_r == `WSRC_ENERGY) && energy_en_r);
    // Energy only counts as an event when its enable is set, else the flag would never clear.
    wire new_event = (frame_hit && src_r != `WSRC_FRAME)
        || (energy_hit && energy_en_r && src_r != `WSRC_ENERGY);
    wire pulse_busy;

    wake_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(new_event && pulse_sel_r),
        .clear_i(!wpin_en_r || (!cause && !new_event)),
        .busy_o(pulse_busy)
    );

    // Event inputs come from line-side clocks.
    always @(posedge clk_i) begin
        if (rst_i) begin
            frame_s1_r <= 1'b0;
            frame_s2_r <= 1'b0;
            energy_s1_r <= 1'b0;
            energy_s2_r <= 1'b0;
            energy_d_r <= 1'b0;
        end else begin
            frame_s1_r <= wake_frame_i;
            frame_s2_r <= frame_s1_r;
            energy_s1_r <= line_energy_present_i;
            energy_s2_r <= energy_s1_r;
            energy_d_r <= energy_s2_r;
        end
    end

    // Power state sequence and ready flag.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_NORMAL;
            restart_cnt_r <= 8'h00;
            ready_r <= 1'b1;
            sel_state_r <= `PSTATE_NORMAL;
        end else begin
            case (state_r)
                ST_NORMAL: begin
                    if (pm_enter_wol) begin
                        state_r <= ST_WOL;
                        sel_state_r <= `PSTATE_WOL;
                        ready_r <= 1'b0;
                    end else if (pm_enter_energy) begin
                        state_r <= ST_ENERGY;
                        sel_state_r <= `PSTATE_ENERGY;
                        ready_r <= 1'b0;
                    end
                end
                ST_WOL, ST_ENERGY: begin
                    if (wake_wr) begin
                        state_r <= ST_RESTART;
                        sel_state_r <= `PSTATE_NORMAL;
                        restart_cnt_r <= 8'h00;
                    end
                end
                ST_RESTART: begin
                    // Ready waits until the gated clocks have run long enough to settle.
                    if (restart_cnt_r == RESTART_LAST) begin
                        state_r <= ST_NORMAL;
                        ready_r <= 1'b1;
                    end else begin
                        restart_cnt_r <= restart_cnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_NORMAL;
                    sel_state_r <= `PSTATE_NORMAL;
                    ready_r <= 1'b1;
                end
            endcase
        end
    end

    // Clock enables follow the state; MAC and host clocks resume in restart.
    always @(posedge clk_i) begin
        if (rst_i) begin
            mac_clk_en_o <= 1'b1;
            host_clk_en_o <= 1'b1;
            int_clk_en_o <= 1'b1;
            rx_pm_clk_en_o <= 1'b1;
            phy_energy_mode_o <= 1'b0;
        end else begin
            mac_clk_en_o <= !(in_wol || in_energy);
            host_clk_en_o <= !(in_wol || in_energy);
            int_clk_en_o <= !in_energy;
            rx_pm_clk_en_o <= !in_energy;
            phy_energy_mode_o <= in_energy && phy_edpd_r;
        end
    end

    // Control fields keep their values across low-power states.
    always @(posedge clk_i) begin
        if (rst_i) begin
            read_seen_r <= 1'b0;
            wpin_en_r <= 1'b0;
            pulse_sel_r <= 1'b0;
            frame_en_r <= 1'b0;
            energy_en_r <= 1'b0;
            src_r <= `WSRC_NONE;
            int_wake_r <= 1'b0;
            int_en_r <= 1'b0;
            phy_gpd_r <= 1'b0;
            phy_edpd_r <= 1'b0;
            phy_enflag_r <= 1'b0;
        end else begin
            if (rd) begin
                read_seen_r <= 1'b1;
            end else if (wake_wr) begin
                read_seen_r <= 1'b0;
            end
            if (pm_wr) begin
                wpin_en_r <= pm_new[`PM_WPIN_EN_BIT];
                pulse_sel_r <= pm_new[`PM_PULSE_BIT];
                frame_en_r <= pm_new[`PM_FRAME_EN_BIT];
                energy_en_r <= pm_new[`PM_ENERGY_EN_BIT];
            end
            if (frame_hit) begin
                src_r <= `WSRC_FRAME;
            end else if (energy_hit && energy_en_r) begin
                src_r <= `WSRC_ENERGY;
            end else if (pm_wr) begin
                src_r <= pm_new[`PM_SRC_HI:`PM_SRC_LO];
            end
            // Sticky while the cause holds; a write of one clears only after that.
            if (cause || new_event) begin
                int_wake_r <= 1'b1;
            end else if (interrupt_status_reg_wr && sel_i[2] && dat_i[`INT_WAKE_BIT]) begin
                int_wake_r <= 1'b0;
            end
            if (int_en_wr && sel_i[2]) begin
                int_en_r <= dat_i[`INT_WAKE_BIT];
            end
            if (phy_ctrl_wr && sel_i[1]) begin
                phy_gpd_r <= dat_i[`PHY_GPD_BIT];
                phy_edpd_r <= dat_i[`PHY_EDPD_BIT];
            end
            if (phy_edpd_r && energy_s2_r && !energy_d_r) begin
                phy_enflag_r <= 1'b1;
            end else if (phy_sts_wr && sel_i[0] && dat_i[`PHY_ENFLAG_BIT]) begin
                phy_enflag_r <= 1'b0;
            end
        end
    end

    // Wake output and PHY power-down outputs.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_level_r <= 1'b0;
            wake_event_o <= 1'b0;
            wake_irq_o <= 1'b0;
            phy_powerdown_o <= 1'b0;
            phy_reset_o <= 1'b0;
            phy_gpd_d_r <= 1'b0;
        end else begin
            // The cause shows one cycle after the event, so the event cycle itself must not clear.
            if (!wpin_en_r || (!cause && !new_event)) begin
                wake_level_r <= 1'b0;
            end else if (new_event && !pulse_sel_r) begin
                wake_level_r <= 1'b1;
            end
            wake_event_o <= wpin_en_r && cause && (pulse_sel_r ? pulse_busy : wake_level_r);
            wake_irq_o <= int_wake_r && int_en_r;
            phy_gpd_d_r <= phy_gpd_r;
            // PHY sleeps while general power-down is set, or idles in energy mode.
            phy_powerdown_o <= phy_gpd_r || (phy_edpd_r && !energy_s2_r);
            phy_reset_o <= phy_gpd_d_r && !phy_gpd_r;
        end
    end

    // Read mux; only the power control register answers while not ready.
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (adr_i)
            `ADDR_PMCTRL: rd_nxt = pm_word;
            `ADDR_INTSTS: rd_nxt = ready_r ? ({31'h0000_0000, int_wake_r} << `INT_WAKE_BIT) : 32'h0000_0000;
            `ADDR_INTEN: rd_nxt = ready_r ? ({31'h0000_0000, int_en_r} << `INT_WAKE_BIT) : 32'h0000_0000;
            `ADDR_WAKETEST: rd_nxt = ready_r ? `WAKE_TEST_VALUE : 32'h0000_0000;
            `ADDR_PHYCTRL: rd_nxt = ready_r ? (({31'h0000_0000, phy_gpd_r} << `PHY_GPD_BIT)
                | ({31'h0000_0000, phy_edpd_r} << `PHY_EDPD_BIT)) : 32'h0000_0000;
            `ADDR_PHYSTS: rd_nxt = ready_r ? ({31'h0000_0000, phy_enflag_r} << `PHY_ENFLAG_BIT) : 32'h0000_0000;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Every access, mapped or not, is acknowledged one cycle after the strobe.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (rd) begin
                dat_o <= rd_nxt;
            end
        end
    end
endmodule // pwr_state_mgr

/* File: dv/pwr_state_mgr_checker.sv */
/*
 * Concurrent checks on the power state manager ports.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module pwr_state_mgr_checker #(
    parameter PULSE_CYCLES = 500000,
    parameter RESTART_CYCLES = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus and line side.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic ack_o,
    input wire logic wake_frame_i,
    input wire logic line_energy_present_i,
    // Gating, PHY control and wake outputs.
    input wire logic mac_clk_en_o,
    input wire logic host_clk_en_o,
    input wire logic int_clk_en_o,
    input wire logic rx_pm_clk_en_o,
    input wire logic phy_energy_mode_o,
    input wire logic phy_reset_o,
    input wire logic wake_event_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_wake_wr;
        cyc_i && stb_i && !ack_o && we_i && adr_i == 6'h0C && !mac_clk_en_o;
    endsequence
    a_ack_next: assert property (s_take |=> ack_o) else $error("request not acked next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_wake_restarts: assert property (s_wake_wr |-> ##[2:1000] (mac_clk_en_o && host_clk_en_o))
        else $error("clocks not restarted after wake write");
    a_deep_gates: assert property (!int_clk_en_o |-> !mac_clk_en_o && !host_clk_en_o)
        else $error("energy state left clocks running");
    a_wol_gates: assert property (!mac_clk_en_o |-> !host_clk_en_o)
        else $error("host clock running in sleep");
    a_rx_with_int: assert property (rx_pm_clk_en_o == int_clk_en_o)
        else $error("receive block clock differs from internal clock");
    a_energy_mode: assert property (phy_energy_mode_o |-> !int_clk_en_o)
        else $error("energy mode outside energy state");
    a_event_cause: assert property ($rose(wake_event_o) |-> $past(wake_frame_i, 2) || $past(line_energy_present_i, 2))
        else $error("wake output rose without cause");
    a_event_asleep: assert property ($rose(wake_event_o) |-> !mac_clk_en_o)
        else $error("wake output rose while awake");
    a_reset_vals: assert property ($fell(rst_i) |-> mac_clk_en_o && int_clk_en_o && !wake_event_o && !ack_o)
        else $error("outputs wrong after reset");
    a_phy_rst_pulse: assert property (phy_reset_o |=> !phy_reset_o)
        else $error("phy reset longer than one cycle");
endmodule // pwr_state_mgr_checker

bind pwr_state_mgr pwr_state_mgr_checker #(.PULSE_CYCLES(PULSE_CYCLES), .RESTART_CYCLES(RESTART_CYCLES)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o),
    .wake_frame_i(wake_frame_i), .line_energy_present_i(line_energy_present_i), .mac_clk_en_o(mac_clk_en_o),
    .host_clk_en_o(host_clk_en_o), .int_clk_en_o(int_clk_en_o), .rx_pm_clk_en_o(rx_pm_clk_en_o),
    .phy_energy_mode_o(phy_energy_mode_o), .phy_reset_o(phy_reset_o), .wake_event_o(wake_event_o));

/* File: dv/host_bus_model.sv */
/*
 * Host processor model: classic Wishbone master with a read scoreboard.
 * Assumes the testbench top provides a check task.
 */
`timescale 1ns/1ps
module host_bus_model (
    // Clock.
    input wire logic clk_i,
    // Wishbone master.
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [5:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    logic [63:0] notes[$];
    logic [63:0] note;
    logic [31:0] last_rd;
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 6'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
        last_rd = 32'h0000_0000;
    end
    // Held until ack is sampled, then released for a full cycle.
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        last_rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    // A zero mask makes a read whose value is only polled, not judged.
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({e, m});
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    always @(posedge clk_i) begin
        if (ack_i === 1'b1 && we_o === 1'b0 && notes.size() > 0) begin
            note = notes.pop_front();
            tb_ethernet_power_state_manager.check("read_data", dat_i & note[31:0], note[63:32]);
        end
    end
endmodule // host_bus_model

/* File: dv/tb_ethernet_power_state_manager.sv */
/*
 * Self-checking bench for the power state manager.
 * Assumes the design include path holds the register constants.
 */
`timescale 1ns/1ps
`include "pwr_mgmt_regs.vh"
module tb_ethernet_power_state_manager;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, frame = 1'b0, energy = 1'b0;
    logic mac_en, host_en, int_en, rx_en, phy_pd, phy_em, phy_rst, wake_ev, wake_irq;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    always #50 clk_i = ~clk_i;
    host_bus_model h (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(dat_w), .dat_i(dat_r), .ack_i(ack));
    pwr_state_mgr #(.PULSE_CYCLES(20), .RESTART_CYCLES(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .wake_frame_i(frame), .line_energy_present_i(energy), .mac_clk_en_o(mac_en), .host_clk_en_o(host_en),
        .int_clk_en_o(int_en), .rx_pm_clk_en_o(rx_en), .phy_powerdown_o(phy_pd), .phy_energy_mode_o(phy_em),
        .phy_reset_o(phy_rst), .wake_event_o(wake_ev), .wake_irq_o(wake_irq));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Polls ready; each poll costs three cycles, so the count bounds the wake time.
    task automatic wait_ready;
        h.last_rd = 32'h0000_0000;
        n = 0;
        while (h.last_rd[0] !== 1'b1 && n < 2000) begin
            h.rd(`ADDR_PMCTRL, 32'h0000_0000, 32'h0000_0000);
            n++;
        end
        check("ready_time", {31'h0000_0000, n < 2000 && n * 3 <= 20000}, 32'h0000_0001);
        check("clocks_back", {28'h000_0000, mac_en, host_en, int_en, rx_en}, 32'h0000_000F);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(85901));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        h.wr(`ADDR_INTEN, 32'h0002_0000);
        h.rd(`ADDR_INTEN, 32'h0000_0000, 32'hFFFF_FFFF);
        h.wr(`ADDR_INTEN, 32'h0002_0000);
        h.rd(`ADDR_INTEN, 32'h0002_0000, 32'hFFFF_FFFF);
        h.rd(`ADDR_WAKETEST, `WAKE_TEST_VALUE, 32'hFFFF_FFFF);
        h.wr(`ADDR_PMCTRL, 32'h0000_1202);
        repeat (2) @(posedge clk_i);
        check("wol_clocks", {28'h000_0000, mac_en, host_en, int_en, rx_en}, 32'h0000_0003);
        h.rd(`ADDR_PMCTRL, 32'h0000_1000, 32'h0000_3001);
        h.rd(`ADDR_INTEN, 32'h0000_0000, 32'hFFFF_FFFF);
        frame <= 1'b1;
        repeat (8 + $urandom % 8) @(posedge clk_i);
        frame <= 1'b0;
        check("wol_event", {30'h0000_0000, wake_ev, wake_irq}, 32'h0000_0003);
        h.rd(`ADDR_PMCTRL, 32'h0000_0020, 32'h0000_0030);
        h.wr(`ADDR_WAKETEST, $urandom());
        wait_ready();
        h.rd(`ADDR_PMCTRL, 32'h0000_0001, 32'h0000_3001);
        h.rd(`ADDR_INTEN, 32'h0002_0000, 32'hFFFF_FFFF);
        repeat (30) @(posedge clk_i);
        check("level_hold", {31'h0000_0000, wake_ev}, 32'h0000_0001);
        h.wr(`ADDR_INTSTS, 32'h0002_0000);
        h.rd(`ADDR_INTSTS, 32'h0002_0000, 32'h0002_0000);
        h.wr(`ADDR_PMCTRL, 32'h0000_0200);
        @(posedge clk_i);
        check("pin_off", {31'h0000_0000, wake_ev}, 32'h0000_0000);
        h.wr(`ADDR_PMCTRL, 32'h0000_0000);
        h.wr(`ADDR_INTSTS, 32'h0002_0000);
        h.rd(`ADDR_INTSTS, 32'h0000_0000, 32'h0002_0000);
        check("irq_off", {31'h0000_0000, wake_irq}, 32'h0000_0000);
        // Carrier is already up before entry, so detection must not wait for an edge.
        energy <= 1'b1;
        h.wr(`ADDR_PHYCTRL, 32'h0000_2000);
        h.wr(`ADDR_PMCTRL, 32'h0000_240A);
        n = 0;
        while (wake_ev !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        check("edge_free_detect", {31'h0000_0000, n < 50}, 32'h0000_0001);
        check("energy_gates", {26'h000_0000, mac_en, host_en, int_en, rx_en, phy_em, phy_pd}, 32'h0000_0002);
        n = 0;
        while (wake_ev === 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        check("pulse_len", n, 32'd20);
        h.rd(`ADDR_PMCTRL, 32'h0000_0010, 32'h0000_0031);
        h.wr(`ADDR_WAKETEST, $urandom());
        wait_ready();
        h.rd(`ADDR_PHYSTS, 32'h0000_0002, 32'h0000_0002);
        energy <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("ed_sleep", {31'h0000_0000, phy_pd}, 32'h0000_0001);
        h.wr(`ADDR_PHYCTRL, 32'h0000_0000);
        h.rd(`ADDR_PHYCTRL, 32'h0000_0000, 32'h0000_2000);
        energy <= 1'b0;
        h.wr(`ADDR_PHYCTRL, 32'h0000_0800);
        check("gen_powerdown", {31'h0000_0000, phy_pd}, 32'h0000_0001);
        h.wr(`ADDR_PHYCTRL, 32'h0000_0000);
        n = 0;
        while (phy_rst !== 1'b1 && n < 6) begin
            @(posedge clk_i);
            n++;
        end
        check("phy_reset", {31'h0000_0000, phy_rst, phy_pd}, 32'h0000_0002);
        close_out();
    end
endmodule // tb_ethernet_power_state_manager
